// ---- src/twei_defs.vh ----
/*
 * Constants shared by the two-wire serial memory slave: device address word
 * layout, memory geometry and the rewrite cycle timing.
 * Assumes it is included by bare name from files under src/.
 */
`ifndef TWEI_DEFS_VH
`define TWEI_DEFS_VH

// Device address word fields, bit 7 is received first.
`define TWEI_TYPE_MSB        7
`define TWEI_TYPE_LSB        4
`define TWEI_SEL_MSB         3
`define TWEI_SEL_LSB         1
`define TWEI_RW_BIT          0

// Value of the read/write bit that requests a read.
`define TWEI_RW_READ         1'b1

// Bits per transferred group and the index of the acknowledge clock.
`define TWEI_BITS_PER_BYTE   4'h8
`define TWEI_ACK_CLOCK       4'h9

// Memory geometry: address width and in-page offset width (32-byte pages).
`define TWEI_MEM_AW          8
`define TWEI_PAGE_AW         5

// System clock rate and the longest rewrite cycle, in microseconds.
`define TWEI_CLK_MHZ         100
`define TWEI_REWRITE_TIME_US 10000
`define TWEI_REWRITE_CYCLES  (`TWEI_REWRITE_TIME_US * `TWEI_CLK_MHZ)

`endif

// ---- src/twei_line_sync.v ----
/*
 * Synchroniser and condition detector for the serial clock and data pins.
 * Assumes both pins are asynchronous to clock and are sampled far faster than
 * the bus toggles (clock at 100 MHz, serial clock period 120 ns or more).
 */
`timescale 1ns/1ns
`default_nettype none

module twei_line_sync
(
  input  wire clock,
  input  wire resetn,
  input  wire scl_pin,
  input  wire sda_pin,
  output wire scl_level,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_seen,
  output wire stop_seen
);

  // First stages are read only by the second stages.
  reg scl_meta_reg;
  reg sda_meta_reg;
  // Stable synchronised levels.
  reg scl_sync_reg;
  reg sda_sync_reg;
  // Previous stable levels for edge detection.
  reg scl_prev_reg;
  reg sda_prev_reg;

  // Two flip-flops per pin, then one history stage. Idle bus reads high.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_meta_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_meta_reg <= scl_pin;
      sda_meta_reg <= sda_pin;
      scl_sync_reg <= scl_meta_reg;
      sda_sync_reg <= sda_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  assign scl_level = scl_sync_reg;
  assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
  // start detect: data falls while the clock stays high.
  assign start_seen = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  // stop detect: data rises while the clock stays high.
  assign stop_seen  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

endmodule // twei_line_sync

`default_nettype wire

// ---- src/twei_slave.v ----
/*
 * Memory side of a two-wire serial EEPROM: device address decode, random
 * address load, 32-byte page write with rewrite cycle, acknowledge polling
 * and sequential read. The memory array lives inside this module.
 * Assumes an external pull-up on the data line; this module only pulls low.
 * The serial clock comes from the host and is sampled by clock.
 */
// Notes on behaviour
// - Start condition opens every transaction.
// - Stop condition closes every transaction.
// - Stop during read returns to standby.
// - Stop after write data runs rewrite, then standby.
// - Eight-bit groups; receiver pulls ninth clock low.
// - Transmitter releases data on ninth clock.
// - After read byte, release; stop means standby.
// - No acknowledge: stop output, keep released.
// - Address word: type, select, read/write.
// - Select code compared with strapped pins.
// - Last bit zero writes, one reads.
// - Mismatched type or select is ignored.
// - Further bytes advance five-bit in-page offset.
// - Offset wraps in page; latest byte wins.
// - Stop after page data starts rewrite.
// - Polling: no acknowledge while rewriting.
// - Polling starts only after the stop.
// - Host acknowledge advances sequential read address.
// - Read address wraps to zero.
`timescale 1ns/1ns
`default_nettype none
`include "twei_defs.vh"

module twei_slave
#(
  parameter [3:0] TYPE_CODE      = 4'h5,  // Arbitrary device type code.
  parameter       MEM_AW         = `TWEI_MEM_AW,
  parameter       PAGE_AW        = `TWEI_PAGE_AW,
  parameter       TMR_W          = 20,
  parameter [TMR_W-1:0] REWRITE_CYCLES = `TWEI_REWRITE_CYCLES
)
(
  input  wire       clock,
  input  wire       resetn,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire [2:0] device_select_pins,
  output wire       rewrite_busy
);

  localparam PAGE_SIZE = 1 << PAGE_AW;
  localparam MEM_SIZE  = 1 << MEM_AW;

  // Transaction states.
  localparam [2:0] ST_IDLE  = 3'h0;  // Standby, waiting for a start.
  localparam [2:0] ST_DEV   = 3'h1;  // Receiving the device address word.
  localparam [2:0] ST_ADDR  = 3'h2;  // Receiving the memory address.
  localparam [2:0] ST_WDATA = 3'h3;  // Receiving write data.
  localparam [2:0] ST_RDATA = 3'h4;  // Sending read data.
  localparam [2:0] ST_HOLD  = 3'h5;  // Line released until next start/stop.

  // Conditioned bus events from the synchroniser.
  wire scl_level;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;

  twei_line_sync u_sync
  (
    .clock      (clock),
    .resetn     (resetn),
    .scl_pin    (scl_in),
    .sda_pin    (sda_in),
    .scl_level  (scl_level),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  // The data pin also needs its own synchronised copy for bit sampling.
  reg  sda_meta_reg;
  reg  sda_sync_reg;
  // Strap pins are quasi-static but still pass two flip-flops.
  reg  [2:0] sel_meta_reg;
  reg  [2:0] sel_sync_reg;

  reg  [2:0]         state_reg;     // Transaction state.
  reg  [3:0]         bit_cnt_reg;   // Serial clock rises in this group.
  reg  [7:0]         rx_reg;        // Incoming shift register.
  reg  [7:0]         tx_reg;        // Outgoing shift register.
  reg                drive_low_reg; // One pulls the data line low.
  reg                host_ack_reg;  // Host acknowledged the last read byte.
  reg  [MEM_AW-1:0]  addr_reg;      // Current memory address.
  reg  [PAGE_SIZE-1:0] pvalid_reg;  // Page buffer entries holding data.
  reg                busy_reg;      // Rewrite cycle in progress.
  reg                copy_reg;      // Page buffer copy in progress.
  reg  [PAGE_AW-1:0] copy_idx_reg;  // Entry being copied.
  reg  [TMR_W-1:0]   timer_reg;     // Rewrite cycle counter.
  reg  [MEM_AW-1:PAGE_AW] page_reg; // Page captured for the rewrite.

  // Storage arrays; no reset, contents are undefined at power-up.
  reg  [7:0] mem_array [0:MEM_SIZE-1];
  reg  [7:0] page_buf  [0:PAGE_SIZE-1];

  // Byte just completed, including the bit sampled on the eighth rise.
  wire [7:0] rx_byte = rx_reg;
  wire       type_ok = (rx_byte[`TWEI_TYPE_MSB:`TWEI_TYPE_LSB] == TYPE_CODE);
  wire       sel_ok  = (rx_byte[`TWEI_SEL_MSB:`TWEI_SEL_LSB] == sel_sync_reg);
  wire [PAGE_AW-1:0] page_off = addr_reg[PAGE_AW-1:0];

  // Synchronisers for the sampled data bit and the straps.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sel_meta_reg <= 3'h0;
      sel_sync_reg <= 3'h0;
    end
    else
    begin
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sel_meta_reg <= device_select_pins;
      sel_sync_reg <= sel_meta_reg;
    end
  end

  // Main protocol engine. Start and stop take priority over clock edges,
  // because a condition is itself a data change while the clock is high.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      drive_low_reg <= 1'b0;
      host_ack_reg  <= 1'b0;
      addr_reg      <= {MEM_AW{1'b0}};
      pvalid_reg    <= {PAGE_SIZE{1'b0}};
    end
    else if (start_seen)
    begin
      // start opens address word reception.
      // A repeated start drops any unflushed page data, but never while the
      // rewrite copy still reads the valid flags, or a poll would clip it.
      state_reg     <= ST_DEV;
      bit_cnt_reg   <= 4'h0;
      drive_low_reg <= 1'b0;
      if (!busy_reg)
        pvalid_reg  <= {PAGE_SIZE{1'b0}};
    end
    else if (stop_seen)
    begin
      // reads simply end here; writes hand off below.
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      drive_low_reg <= 1'b0;
    end
    else if (state_reg != ST_IDLE && state_reg != ST_HOLD)
    begin
      if (scl_rise)
      begin
        // eight data bits are sampled on rising clock edges.
        if (bit_cnt_reg < `TWEI_BITS_PER_BYTE)
          rx_reg <= {rx_reg[6:0], sda_sync_reg};
        // on the ninth clock a read samples the host answer.
        else if (state_reg == ST_RDATA)
          host_ack_reg <= ~sda_sync_reg;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      else if (scl_fall)
      begin
        if (bit_cnt_reg == `TWEI_BITS_PER_BYTE)
        begin
          // A group of eight has ended; decide the ninth clock.
          case (state_reg)
            ST_DEV:
            begin
              // foreign type or select: ignore, back to standby.
              // while rewriting, leave the line high (no ack).
              if (!type_ok || !sel_ok || busy_reg)
                state_reg <= ST_IDLE;
              else
              begin
                drive_low_reg <= 1'b1;
                if (rx_byte[`TWEI_RW_BIT] == `TWEI_RW_READ)
                begin
                  state_reg    <= ST_RDATA;
                  host_ack_reg <= 1'b1;
                end
                else
                  state_reg <= ST_ADDR;
              end
            end
            ST_ADDR:
            begin
              // Random address load; a dummy write stops here.
              addr_reg      <= rx_byte[MEM_AW-1:0];
              drive_low_reg <= 1'b1;
              state_reg     <= ST_WDATA;
            end
            ST_WDATA:
            begin
              // each byte advances only the in-page offset.
              // the offset wraps inside the page.
              addr_reg[PAGE_AW-1:0] <= page_off + {{(PAGE_AW-1){1'b0}}, 1'b1};
              pvalid_reg[page_off]  <= 1'b1;
              drive_low_reg         <= 1'b1;
            end
            ST_RDATA:
            begin
              // transmitter releases the line for the answer.
              drive_low_reg <= 1'b0;
            end
            default:
              state_reg <= ST_IDLE;
          endcase
        end
        else if (bit_cnt_reg == `TWEI_ACK_CLOCK)
        begin
          // Ninth clock over: release and start the next group.
          bit_cnt_reg   <= 4'h0;
          drive_low_reg <= 1'b0;
          if (state_reg == ST_RDATA)
          begin
            if (host_ack_reg)
            begin
              // fetch the byte and advance the address.
              // the increment wraps to location zero.
              tx_reg        <= {mem_array[addr_reg][6:0], 1'b0};
              drive_low_reg <= ~mem_array[addr_reg][7];
              addr_reg      <= addr_reg + {{(MEM_AW-1){1'b0}}, 1'b1};
            end
            else
              // no answer: no more data, line stays released.
              state_reg <= ST_HOLD;
          end
        end
        else if (state_reg == ST_RDATA)
        begin
          // a one bit is sent by releasing, never driving high.
          drive_low_reg <= ~tx_reg[7];
          tx_reg        <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Page buffer capture; a location written twice keeps the newer byte.
  always @(posedge clock)
  begin
    // later bytes overwrite earlier ones at the same offset.
    if (scl_fall && !start_seen && !stop_seen && state_reg == ST_WDATA &&
        bit_cnt_reg == `TWEI_BITS_PER_BYTE)
      page_buf[page_off] <= rx_byte;
  end

  // Rewrite cycle: copy valid buffer entries into the array, then hold the
  // busy flag until the full rewrite time has passed. The copy takes only
  // PAGE_SIZE cycles, so REWRITE_CYCLES must not be shorter than that.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_reg     <= 1'b0;
      copy_reg     <= 1'b0;
      copy_idx_reg <= {PAGE_AW{1'b0}};
      timer_reg    <= {TMR_W{1'b0}};
      page_reg     <= {(MEM_AW-PAGE_AW){1'b0}};
    end
    // a stop after page data launches the rewrite.
    // busy only rises here, so polling starts after the stop.
    else if (stop_seen && state_reg == ST_WDATA && (|pvalid_reg))
    begin
      busy_reg     <= 1'b1;
      copy_reg     <= 1'b1;
      copy_idx_reg <= {PAGE_AW{1'b0}};
      timer_reg    <= {TMR_W{1'b0}};
      page_reg     <= addr_reg[MEM_AW-1:PAGE_AW];
    end
    else if (busy_reg)
    begin
      if (copy_reg)
      begin
        copy_idx_reg <= copy_idx_reg + {{(PAGE_AW-1){1'b0}}, 1'b1};
        if (&copy_idx_reg)
          copy_reg <= 1'b0;
      end
      // standby only once the rewrite time has run out.
      if (timer_reg == REWRITE_CYCLES - {{(TMR_W-1){1'b0}}, 1'b1})
        busy_reg <= 1'b0;
      else
        timer_reg <= timer_reg + {{(TMR_W-1){1'b0}}, 1'b1};
    end
  end

  // Array write port, driven only by the rewrite copy.
  always @(posedge clock)
  begin
    if (busy_reg && copy_reg && pvalid_reg[copy_idx_reg])
      mem_array[{page_reg, copy_idx_reg}] <= page_buf[copy_idx_reg];
  end

  // open-drain output: the pin value is always low.
  assign sda_out      = 1'b0;
  assign sda_oe       = drive_low_reg;
  assign rewrite_busy = busy_reg;

endmodule // twei_slave

`default_nettype wire

// ---- testbench/tb_two_wire_eeprom_interface.sv ----
/* Testbench for the serial memory slave, driven by the host model.
   Assumes a pull-up on data: the line is low when either party pulls it. */
`timescale 1ns/1ns
`default_nettype none
module tb_two_wire_eeprom_interface;
  localparam logic [3:0] DEV_TYPE = 4'h5;  // Arbitrary type code.
  localparam logic [2:0] DEV_SEL  = 3'h5;
  localparam int         RW_CYC   = 400;   // Must outlast one polling word.
  logic       clock;
  logic       resetn;
  logic       scl;
  logic       host_low;
  logic       sda_out;
  logic       sda_oe;
  logic       busy;
  logic [2:0] sel_pins;
  logic       ack_n;
  logic [7:0] rd;
  int         err_count;
  int         num_checks;
  wire        sda_line = !((sda_oe && !sda_out) || host_low);
  twei_slave #(.TYPE_CODE(DEV_TYPE), .REWRITE_CYCLES(RW_CYC)) DUT (.clock(clock),
    .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .device_select_pins(sel_pins), .rewrite_busy(busy));
  twei_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl),
    .sda_low(host_low));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  // Start plus address word; exp is the expected ninth-clock level.
  task automatic begin_word(input logic [3:0] t, input logic [2:0] s, input logic rw,
                            input logic exp);
    host.start_cond();
    host.send_byte({t, s, rw}, ack_n);
    check("word ack", {7'h00, exp}, {7'h00, ack_n});
  endtask
  task automatic send_chk(input logic [7:0] d);
    host.send_byte(d, ack_n);
    check("data ack", 8'h00, {7'h00, ack_n});
  endtask
  // Bounded wait for the rewrite to finish; running out ends the run.
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge clock);
    while (busy !== 1'b0 && n < RW_CYC + 100)
    begin
      @(posedge clock);
      n++;
    end
    if (busy !== 1'b0)
    begin
      $display("FAIL rewrite_busy expected 0 seen %b", busy);
      err_count++;
      complete_run();
    end
  endtask
  task automatic write_one(input logic [7:0] a, input logic [7:0] d);
    begin_word(DEV_TYPE, DEV_SEL, 1'b0, 1'b0);
    send_chk(a);
    send_chk(d);
    host.stop_cond();
    wait_idle();
  endtask
  // Dummy write loads the address, then a repeated start turns to reading.
  task automatic read_from(input logic [7:0] a);
    begin_word(DEV_TYPE, DEV_SEL, 1'b0, 1'b0);
    send_chk(a);
    begin_word(DEV_TYPE, DEV_SEL, 1'b1, 1'b0);
  endtask
  // Thirty-four bytes overrun a 32-byte page; poll during and after rewrite.
  task automatic s_page_write();
    begin_word(DEV_TYPE, DEV_SEL, 1'b0, 1'b0);
    send_chk(8'h20);
    for (int i = 0; i < 34; i++)
      send_chk(8'h10 + 8'(i));
    host.stop_cond();
    repeat (4) @(posedge clock);
    check("rewrite_busy", 8'h01, {7'h00, busy});
    begin_word(DEV_TYPE, DEV_SEL, 1'b1, 1'b1);
    host.stop_cond();
    wait_idle();
    begin_word(DEV_TYPE, DEV_SEL, 1'b0, 1'b0);
    host.stop_cond();
    read_from(8'h20);
    host.recv_byte(1'b1, rd);
    check("wrapped byte", 8'h30, rd);
    host.recv_byte(1'b1, rd);
    check("wrapped byte", 8'h31, rd);
    host.recv_byte(1'b0, rd);
    check("next byte", 8'h12, rd);
    host.stop_cond();
    read_from(8'h3f);
    host.recv_byte(1'b0, rd);
    check("page end", 8'h2f, rd);
    host.stop_cond();
  endtask
  // Read across the top of memory, then clock on after a refused byte.
  task automatic s_wrap();
    write_one(8'hff, 8'ha5);
    write_one(8'h00, 8'h5a);
    read_from(8'hff);
    host.recv_byte(1'b1, rd);
    check("last location", 8'ha5, rd);
    host.recv_byte(1'b0, rd);
    check("location zero", 8'h5a, rd);
    host.recv_byte(1'b0, rd);
    check("released line", 8'hff, rd);
    check("sda_oe idle", 8'h00, {7'h00, sda_oe});
    host.stop_cond();
  endtask
  // Foreign type and select codes are ignored; a new strap is honoured.
  task automatic s_mismatch();
    begin_word(4'h3, DEV_SEL, 1'b0, 1'b1);
    host.send_byte(8'h00, ack_n);
    check("ignored ack", 8'h01, {7'h00, ack_n});
    host.stop_cond();
    begin_word(DEV_TYPE, 3'h4, 1'b1, 1'b1);
    host.stop_cond();
    sel_pins <= 3'h2;
    repeat (4) @(posedge clock);
    begin_word(DEV_TYPE, 3'h2, 1'b0, 1'b0);
    host.stop_cond();
  endtask
  initial
  begin
    resetn = 1'b0;
    sel_pins = DEV_SEL;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    check("sda_oe reset", 8'h00, {7'h00, sda_oe});
    check("busy reset", 8'h00, {7'h00, busy});
    s_page_write();
    s_wrap();
    s_mismatch();
    complete_run();
  end
endmodule // tb_two_wire_eeprom_interface
`default_nettype wire

// ---- testbench/twei_host_model.sv ----
/* Host model: a controller that bit-bangs the serial clock and pulls data low.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ns
`default_nettype none
module twei_host_model
(
  input  wire logic clock,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  // High phase alternates 4 and 5 cycles, giving a 125 ns mean clock period.
  logic long_hi = 1'b0;
  // The clock stands high and data is released between frames.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // pull low only: data is set mid-low and sampled in the high phase.
  task automatic bit_cycle(input logic b, output logic s);
    tick(4);
    sda_low <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(2);
    s = sda_line;
    tick(long_hi ? 3 : 2);
    long_hi = ~long_hi;
    scl <= 1'b0;
  endtask
  // start: data falls while the clock is high, also as a repeated start.
  task automatic start_cond();
    tick(4);
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  // stop: data rises while the clock is high.
  task automatic stop_cond();
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  // eight bits then released: the ninth clock returns the acknowledge.
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(d[i], s);
    bit_cycle(1'b1, ack_n);
  endtask
  // last byte: a host that is done leaves the ninth clock released.
  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, d[i]);
    bit_cycle(~give_ack, s);
  endtask
endmodule // twei_host_model
`default_nettype wire

// ---- testbench/twei_slave_props.sv ----
/* Checker for the serial memory slave, watching only its top ports.
   Assumes the pins change just after a clock edge, as the bench drives them. */
`timescale 1ns/1ns
`default_nettype none
module twei_slave_props
#(
  parameter logic [3:0] TYPE_CODE      = 4'h5,
  parameter int         REWRITE_CYCLES = 64
)
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [2:0] device_select_pins,
  input wire logic       rewrite_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Pin history, taken from the raw pins so the design's own sync is not trusted.
  logic        scl_d;
  logic        sda_d;
  logic        started;
  logic [3:0]  rise_cnt;
  logic [7:0]  word;
  logic [4:0]  fall_age;
  logic [4:0]  stop_age;
  logic [19:0] busy_cnt;
  wire pin_start = scl_d && scl_in && sda_d && !sda_in;
  wire pin_stop  = scl_d && scl_in && !sda_d && sda_in;
  wire pin_rise  = !scl_d && scl_in;
  // A word naming another device must leave the line alone until a new start.
  wire mismatch  = started && rise_cnt >= 4'h8 &&
                   (word[7:4] != TYPE_CODE || word[3:1] != device_select_pins);
  // Ages saturate at 31 so that an old edge never looks recent.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      {scl_d, sda_d, started} <= 3'h6;
      rise_cnt <= 4'hf;
      word <= 8'h00;
      {fall_age, stop_age} <= 10'h3ff;
      busy_cnt <= 20'h0_0000;
    end
    else
    begin
      {scl_d, sda_d} <= {scl_in, sda_in};
      started <= started || pin_start;
      rise_cnt <= pin_start ? 4'h0 : rise_cnt + {3'h0, pin_rise && rise_cnt != 4'hf};
      if (pin_rise && rise_cnt < 4'h8)
        word <= {word[6:0], sda_in};
      fall_age <= (scl_d && !scl_in) ? 5'h00 : fall_age + {4'h0, fall_age != 5'h1f};
      stop_age <= pin_stop ? 5'h00 : stop_age + {4'h0, stop_age != 5'h1f};
      busy_cnt <= rewrite_busy ? busy_cnt + 20'h0_0001 : 20'h0_0000;
    end
  end
  a_out_low: assert property (sda_out == 1'b0)
    else $error("data output value not zero");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_oe_after_fall: assert property ($rose(sda_oe) |-> fall_age inside {[2:6]})
    else $error("data drive not tied to a clock fall");
  a_word_ack_pos: assert property ($rose(sda_oe) && rise_cnt < 4'h9 |-> rise_cnt == 4'h8)
    else $error("drive inside the address word");
  a_select_quiet: assert property ($rose(sda_oe) |-> !mismatch)
    else $error("drive after a foreign address word");
  a_busy_after_stop: assert property ($rose(rewrite_busy) |-> stop_age <= 5'h06)
    else $error("rewrite began without a stop");
  a_busy_length: assert property (
    $fell(rewrite_busy) |-> busy_cnt inside {[REWRITE_CYCLES-1:REWRITE_CYCLES+1]})
    else $error("rewrite length wrong");
  a_busy_silent: assert property (rewrite_busy |-> !sda_oe)
    else $error("acknowledge during rewrite");
  c_rewrite: cover property ($fell(rewrite_busy));
  c_foreign: cover property (mismatch && pin_rise);
  c_ack: cover property ($rose(sda_oe) && rise_cnt == 4'h8);
endmodule // twei_slave_props
bind twei_slave twei_slave_props #(.TYPE_CODE(TYPE_CODE), .REWRITE_CYCLES(REWRITE_CYCLES))
  u_props (.clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(device_select_pins),
  .rewrite_busy(rewrite_busy));
`default_nettype wire
